// ===== pci_card_defs.svh
// Purpose: shared constants of the card host adapter target port
// Assumes: core clock at 100 MHz
// Notes: commands are the raw levels on the command/byte-enable pins
`ifndef PCI_CARD_DEFS_SVH
`define PCI_CARD_DEFS_SVH
`define CORE_MHZ 100
`define CB_MAX_MHZ 33
`define CB_MIN_DIV ((`CORE_MHZ + `CB_MAX_MHZ - 1) / `CB_MAX_MHZ)
`define LP_IDLE_NS 2000
`define LP_IDLE_CYC ((`LP_IDLE_NS * `CORE_MHZ) / 1000)
`define NUM_SOCK 2
`define WIN_PER_SOCK 7
`define NUM_WIN 14
`define CMD_IO_RD 4'h2
`define CMD_IO_WR 4'h3
`define CMD_MEM_RD 4'h6
`define CMD_MEM_WR 4'h7
`define CMD_CFG_RD 4'hA
`define CMD_CFG_WR 4'hB
`define CMD_MEM_RDM 4'hC
`define CMD_MEM_RDL 4'hE
`define CMD_MEM_WRI 4'hF
`define LEGACY_IO_MASK 32'h00000003
`define LEGACY_MEM_MASK 32'h00000FFF
`endif

// ===== pci_card_pkg.sv
// Purpose: types of the card host adapter target port
// Assumes: nothing
// Notes: states are one-hot
package pci_card_pkg;
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_DATA = 5'h02,
        ST_STOP = 5'h04,
        ST_TURN = 5'h08,
        ST_BUSY = 5'h10
    } tgt_state_t;
    typedef enum logic [1:0] {
        IRQ_PCI = 2'h0,
        IRQ_SERIAL = 2'h1,
        IRQ_EXTSHIFT = 2'h2,
        IRQ_VENDOR = 2'h3
    } irq_mode_t;
    typedef enum logic [1:0] {
        ACC_CFG = 2'h0,
        ACC_MEM = 2'h1,
        ACC_IO = 2'h2,
        ACC_LEGACY = 2'h3
    } acc_kind_t;
endpackage

// ===== win_decoder.sv
// Purpose: per-socket address windows with two lookup ports
// Assumes: windows programmed while idle
// Notes: lowest window index wins on overlap
`timescale 1ns/1ns
`include "pci_card_defs.svh"
module win_decoder (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic win_we,
    input wire logic win_sock,
    input wire logic [2:0] win_idx,
    input wire logic win_en,
    input wire logic win_io,
    input wire logic win_xlate,
    input wire logic [31:0] win_base,
    input wire logic [31:0] win_limit,
    input wire logic [31:0] host_addr,
    input wire logic host_io,
    output logic host_hit,
    output logic host_sock,
    output logic [2:0] host_win,
    output logic host_xlate,
    input wire logic [31:0] mst_addr,
    output logic mst_hit,
    output logic mst_sock
);
    logic [31:0] base_q [`NUM_WIN];
    logic [31:0] limit_q [`NUM_WIN];
    logic [`NUM_WIN-1:0] en_q;
    logic [`NUM_WIN-1:0] io_q;
    logic [`NUM_WIN-1:0] xl_q;
    logic [3:0] wr_idx;
    logic wr_ok;
    logic [5:0] mst_res;

    // io windows with translation also answer memory commands as card io
    function automatic logic [5:0] lookup(input logic [31:0] a, input logic io);
        logic [5:0] r;
        r = 6'h00;
        for (int i = `NUM_WIN - 1; i >= 0; i--) begin
            if (en_q[i] && a >= base_q[i] && a <= limit_q[i] &&
                (io_q[i] ? (io || xl_q[i]) : !io)) begin
                r = {1'b1, i >= `WIN_PER_SOCK,
                     3'(i >= `WIN_PER_SOCK ? i - `WIN_PER_SOCK : i),
                     io_q[i] && !io};
            end
        end
        return r;
    endfunction

    assign wr_idx = win_sock ? 4'(win_idx) + 4'h7 : 4'(win_idx);
    assign wr_ok = win_we && win_idx != 3'h7;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            en_q <= '0;
            io_q <= '0;
            xl_q <= '0;
            for (int i = 0; i < `NUM_WIN; i++) begin
                base_q[i] <= 32'h00000000;
                limit_q[i] <= 32'h00000000;
            end
        end else if (wr_ok) begin
            en_q[wr_idx] <= win_en;
            io_q[wr_idx] <= win_io;
            xl_q[wr_idx] <= win_xlate;
            base_q[wr_idx] <= win_base;
            limit_q[wr_idx] <= win_limit;
        end
    end

    // memory to io translation
    // always_comb so a window write re-runs the lookup, not only an address change
    always_comb {host_hit, host_sock, host_win, host_xlate} = lookup(host_addr, host_io);
    always_comb mst_res = lookup(mst_addr, 1'b0);
    assign mst_hit = mst_res[5];
    assign mst_sock = mst_res[4];
endmodule // win_decoder

// ===== pci_card_host_adapter_port.sv
// Purpose: target side of a two-socket card host adapter on a parallel host bus
// Assumes: bus pins pass two flip-flops before use, so answers lag two cycles
// Notes: one data phase per access; longer bursts are disconnected with stop
`timescale 1ns/1ns
`include "pci_card_defs.svh"
module pci_card_host_adapter_port
    import pci_card_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [31:0] ad,
    output logic [31:0] ad_drv,
    output logic ad_oe_n,
    input wire logic [3:0] cbe_n,
    input wire logic frame_n,
    input wire logic irdy_n,
    output logic trdy_n,
    output logic trdy_oe_n,
    output logic stop_n,
    output logic stop_oe_n,
    input wire logic devsel_n,
    output logic devsel_drv_n,
    output logic devsel_oe_n,
    input wire logic lock_n,
    input wire logic idsel,
    input wire logic par,
    output logic par_drv,
    output logic par_oe_n,
    output logic perr_n,
    output logic perr_oe_n,
    output logic serr_n,
    output logic serr_oe_n,
    input wire logic suspend_hw,
    input wire logic suspend_sw,
    input wire logic auto_lp_en,
    output logic int_clk_en,
    input wire logic [1:0] sock_en,
    input wire logic [1:0][3:0] card_div,
    output logic [1:0] card_clk,
    output logic [1:0] card_clk_en,
    input wire logic legacy_en,
    input wire logic [31:0] legacy_io_base,
    input wire logic [31:0] legacy_mem_base,
    input wire logic win_we,
    input wire logic win_sock,
    input wire logic [2:0] win_idx,
    input wire logic win_en,
    input wire logic win_io,
    input wire logic win_xlate,
    input wire logic [31:0] win_base,
    input wire logic [31:0] win_limit,
    input wire irq_mode_t irq_mode_sel,
    output irq_mode_t irq_mode,
    input wire logic [1:0] act_en,
    input wire logic [1:0] act_clr,
    output logic [1:0] act_flag,
    input wire logic mst_valid,
    input wire logic mst_src,
    input wire logic [31:0] mst_addr,
    input wire logic s2s_en,
    output logic s2s_valid,
    output logic s2s_dst,
    output logic [31:0] s2s_addr,
    output logic acc_valid,
    output acc_kind_t acc_kind,
    output logic [31:0] acc_addr,
    output logic acc_write,
    output logic acc_sock,
    output logic [2:0] acc_win,
    output logic acc_xlate,
    input wire logic [31:0] rd_data,
    output logic wr_valid,
    output logic [31:0] wr_data,
    output logic [3:0] wr_be,
    output logic rd_done,
    output logic other_claim
);
    logic [42:0] sync1_q, sync2_q;
    logic [31:0] ad_s, ad_p_q, ad_out_q, acc_addr_q, wr_data_q, s2s_addr_q;
    logic [3:0] cbe_n_s, cbe_p_q, wr_be_q;
    logic frame_n_s, irdy_n_s, devsel_n_s, lock_n_s, idsel_s, par_s, susp_hw_s;
    logic frame_n_p_q, write_q, devsel_q, trdy_q, stop_q, hs_oe_q, ad_oe_q;
    logic par_out_q, par_oe_q, achk_q, wchk_q, perr_q, perr_hold_q, serr_q;
    logic lock_own_q, int_clk_en_q, acc_valid_q, acc_write_q, acc_sock_q;
    logic acc_xlate_q, wr_valid_q, rd_done_q, s2s_valid_q, s2s_dst_q, other_q;
    logic [2:0] acc_win_q;
    logic [7:0] idle_cnt_q;
    logic [1:0][3:0] card_cnt_q;
    logic [1:0] card_clk_q, act_q, card_on_w, hit_vec_w;
    acc_kind_t acc_kind_q, kind_w;
    irq_mode_t irq_mode_q;
    tgt_state_t state_q, state_d;
    logic addr_phase_w, is_cfg_w, is_io_w, is_mem_w, cfg_sel_w, leg_io_w, leg_mem_w;
    logic win_hit_w, win_sock_w, win_xl_w, win_claim_w, claim_w, susp_w, lp_w;
    logic lock_block_w, retry_w, done_w, par_bad_w, wr_next_w, mst_hit_w, mst_sock_w;
    logic [2:0] win_num_w;

    function automatic logic in_span(input logic [31:0] a, input logic [31:0] b,
                                     input logic [31:0] m);
        return (a & ~m) == (b & ~m);
    endfunction

    function automatic logic even_par(input logic [31:0] a, input logic [3:0] c);
        return ^{a, c};
    endfunction

    // never below the divide that keeps the card clock at or under its ceiling
    function automatic logic [3:0] eff_div(input logic [3:0] d);
        return (d < 4'(`CB_MIN_DIV)) ? 4'(`CB_MIN_DIV) : d;
    endfunction

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            // idle bus: frame, ready, select, lock high; select line, parity, suspend low
            sync1_q <= {32'h00000000, 4'hF, 7'h78};
            sync2_q <= {32'h00000000, 4'hF, 7'h78};
        end else begin
            sync1_q <= {ad, cbe_n, frame_n, irdy_n, devsel_n, lock_n, idsel, par, suspend_hw};
            sync2_q <= sync1_q;
        end
    end
    assign {ad_s, cbe_n_s, frame_n_s, irdy_n_s, devsel_n_s} = sync2_q[42:4];
    assign {lock_n_s, idsel_s, par_s, susp_hw_s} = sync2_q[3:0];

    assign addr_phase_w = !frame_n_s && frame_n_p_q;
    assign is_cfg_w = cbe_n_s == `CMD_CFG_RD || cbe_n_s == `CMD_CFG_WR;
    assign is_io_w = cbe_n_s == `CMD_IO_RD || cbe_n_s == `CMD_IO_WR;
    assign is_mem_w = cbe_n_s == `CMD_MEM_RD || cbe_n_s == `CMD_MEM_WR ||
                      cbe_n_s == `CMD_MEM_RDM || cbe_n_s == `CMD_MEM_RDL ||
                      cbe_n_s == `CMD_MEM_WRI;
    assign cfg_sel_w = is_cfg_w && idsel_s && ad_s[1:0] == 2'h0;
    assign leg_io_w = legacy_en && is_io_w && in_span(ad_s, legacy_io_base, `LEGACY_IO_MASK);
    assign leg_mem_w = legacy_en && is_mem_w &&
                       in_span(ad_s, legacy_mem_base, `LEGACY_MEM_MASK);
    assign win_claim_w = win_hit_w && (is_io_w || is_mem_w) && !leg_io_w && !leg_mem_w;
    assign claim_w = addr_phase_w && state_q == ST_IDLE &&
                     (cfg_sel_w || leg_io_w || leg_mem_w || win_claim_w);
    assign kind_w = cfg_sel_w ? ACC_CFG : (leg_io_w || leg_mem_w) ? ACC_LEGACY :
                    is_io_w ? ACC_IO : ACC_MEM;
    assign susp_w = susp_hw_s || suspend_sw;
    assign lock_block_w = lock_own_q && !lock_n_s && is_mem_w;
    assign retry_w = susp_w || lock_block_w;
    assign done_w = state_q == ST_DATA && trdy_q && !irdy_n_s;
    assign wr_next_w = claim_w ? cbe_n_s[0] : write_q;
    assign par_bad_w = par_s != even_par(ad_p_q, cbe_p_q);
    assign lp_w = auto_lp_en && idle_cnt_q == 8'(`LP_IDLE_CYC);
    assign hit_vec_w = {win_sock_w, !win_sock_w} & {2{claim_w && win_claim_w && !retry_w}};

    win_decoder u_win (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .win_we(win_we),
        .win_sock(win_sock),
        .win_idx(win_idx),
        .win_en(win_en),
        .win_io(win_io),
        .win_xlate(win_xlate),
        .win_base(win_base),
        .win_limit(win_limit),
        .host_addr(ad_s),
        .host_io(is_io_w),
        .host_hit(win_hit_w),
        .host_sock(win_sock_w),
        .host_win(win_num_w),
        .host_xlate(win_xl_w),
        .mst_addr(mst_addr),
        .mst_hit(mst_hit_w),
        .mst_sock(mst_sock_w)
    );

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (claim_w && retry_w) state_d = ST_STOP;
                else if (claim_w) state_d = ST_DATA;
                else if (addr_phase_w) state_d = ST_BUSY;
            end
            ST_DATA: begin
                if (done_w) state_d = frame_n_s ? ST_TURN : ST_STOP;
            end
            ST_STOP: begin
                if (frame_n_s) state_d = ST_TURN;
            end
            ST_TURN: state_d = ST_IDLE;
            ST_BUSY: begin
                if (frame_n_s && irdy_n_s) state_d = ST_IDLE;
            end
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            frame_n_p_q <= 1'b1;
            write_q <= 1'b0;
            devsel_q <= 1'b0;
            trdy_q <= 1'b0;
            stop_q <= 1'b0;
            hs_oe_q <= 1'b0;
            ad_oe_q <= 1'b0;
        end else begin
            state_q <= state_d;
            frame_n_p_q <= frame_n_s;
            write_q <= wr_next_w;
            devsel_q <= state_d == ST_DATA || state_d == ST_STOP;
            // ready after read data is loaded
            trdy_q <= state_q == ST_DATA && state_d == ST_DATA;
            stop_q <= state_d == ST_STOP;
            hs_oe_q <= state_d == ST_DATA || state_d == ST_STOP || state_d == ST_TURN;
            ad_oe_q <= state_d == ST_DATA && !wr_next_w;
        end
    end

    // byte enables taken with the data
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ad_out_q <= 32'h00000000;
            wr_data_q <= 32'h00000000;
            wr_be_q <= 4'h0;
            wr_valid_q <= 1'b0;
            rd_done_q <= 1'b0;
        end else begin
            if (state_q == ST_DATA && !trdy_q) ad_out_q <= rd_data;
            if (done_w && write_q) wr_data_q <= ad_s;
            if (done_w && write_q) wr_be_q <= ~cbe_n_s;
            wr_valid_q <= done_w && write_q;
            rd_done_q <= done_w && !write_q;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_valid_q <= 1'b0;
            acc_kind_q <= ACC_CFG;
            acc_addr_q <= 32'h00000000;
            acc_write_q <= 1'b0;
            acc_sock_q <= 1'b0;
            acc_win_q <= 3'h0;
            acc_xlate_q <= 1'b0;
        end else begin
            acc_valid_q <= claim_w && !retry_w;
            if (claim_w) begin
                acc_kind_q <= kind_w;
                acc_addr_q <= ad_s;
                acc_write_q <= cbe_n_s[0];
                acc_sock_q <= win_sock_w;
                acc_win_q <= win_num_w;
                acc_xlate_q <= win_claim_w && win_xl_w;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ad_p_q <= 32'h00000000;
            cbe_p_q <= 4'h0;
            achk_q <= 1'b0;
            wchk_q <= 1'b0;
            perr_q <= 1'b0;
            perr_hold_q <= 1'b0;
            serr_q <= 1'b0;
            par_out_q <= 1'b0;
            par_oe_q <= 1'b0;
        end else begin
            ad_p_q <= ad_s;
            cbe_p_q <= cbe_n_s;
            achk_q <= addr_phase_w;
            wchk_q <= done_w && write_q;
            perr_q <= wchk_q && par_bad_w;
            perr_hold_q <= perr_q;
            serr_q <= achk_q && par_bad_w;
            par_out_q <= even_par(ad_out_q, cbe_n_s);
            par_oe_q <= ad_oe_q;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) lock_own_q <= 1'b0;
        else if (done_w && !lock_n_s) lock_own_q <= 1'b1;
        else if (state_q == ST_IDLE && frame_n_s && lock_n_s) lock_own_q <= 1'b0;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) idle_cnt_q <= 8'h00;
        else if (state_q != ST_IDLE || addr_phase_w) idle_cnt_q <= 8'h00;
        else if (!lp_w && idle_cnt_q != 8'(`LP_IDLE_CYC)) idle_cnt_q <= idle_cnt_q + 8'h01;
    end

    assign card_on_w = sock_en & {2{!(susp_w || lp_w)}};
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            card_cnt_q <= '0;
            card_clk_q <= 2'h0;
            int_clk_en_q <= 1'b0;
        end else begin
            int_clk_en_q <= !(susp_w || lp_w);
            for (int s = 0; s < `NUM_SOCK; s++) begin
                if (!card_on_w[s] || card_cnt_q[s] >= eff_div(card_div[s]) - 4'h1)
                    card_cnt_q[s] <= 4'h0;
                else
                    card_cnt_q[s] <= card_cnt_q[s] + 4'h1;
                card_clk_q[s] <= card_on_w[s] && card_cnt_q[s] < (eff_div(card_div[s]) >> 1);
            end
        end
    end

    // mode, forwarding, activity (set beats clear)
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_mode_q <= IRQ_PCI;
            act_q <= 2'h0;
            s2s_valid_q <= 1'b0;
            s2s_dst_q <= 1'b0;
            s2s_addr_q <= 32'h00000000;
            other_q <= 1'b0;
        end else begin
            if (state_q == ST_IDLE) irq_mode_q <= irq_mode_sel;
            act_q <= (act_q & ~act_clr) | (act_en & hit_vec_w);
            s2s_valid_q <= s2s_en && mst_valid && mst_hit_w && mst_sock_w != mst_src;
            s2s_dst_q <= mst_sock_w;
            s2s_addr_q <= mst_addr;
            other_q <= state_q == ST_BUSY && !devsel_n_s;
        end
    end

    assign ad_drv = ad_out_q;
    assign ad_oe_n = !ad_oe_q;
    assign trdy_n = !trdy_q;
    assign stop_n = !stop_q;
    assign devsel_drv_n = !devsel_q;
    assign {trdy_oe_n, stop_oe_n, devsel_oe_n} = {3{!hs_oe_q}};
    assign par_drv = par_out_q;
    assign par_oe_n = !par_oe_q;
    assign perr_n = !perr_q;
    assign perr_oe_n = !(perr_q || perr_hold_q);
    assign serr_n = 1'b0;
    assign serr_oe_n = !serr_q;
    assign int_clk_en = int_clk_en_q;
    assign card_clk = card_clk_q;
    assign card_clk_en = card_on_w;
    assign irq_mode = irq_mode_q;
    assign act_flag = act_q;
    assign {s2s_valid, s2s_dst, s2s_addr} = {s2s_valid_q, s2s_dst_q, s2s_addr_q};
    assign {acc_valid, acc_kind, acc_addr, acc_write} =
           {acc_valid_q, acc_kind_q, acc_addr_q, acc_write_q};
    assign {acc_sock, acc_win, acc_xlate} = {acc_sock_q, acc_win_q, acc_xlate_q};
    assign {wr_valid, wr_data, wr_be, rd_done} = {wr_valid_q, wr_data_q, wr_be_q, rd_done_q};
    assign other_claim = other_q;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    cmd_capture_a:
        assert property (acc_valid |-> acc_write == $past(cbe_n_s[0]))
        else $error("access direction not taken from command");
    be_capture_a:
        assert property (wr_valid |-> wr_be == ~$past(cbe_n_s))
        else $error("byte enables not taken from data phase");
    ready_with_select_a:
        assert property (!trdy_n && !trdy_oe_n |-> !devsel_drv_n && !devsel_oe_n)
        else $error("target ready without device select");
    retry_stop_a:
        assert property (claim_w && retry_w |=> !stop_n && !stop_oe_n && trdy_n ##1 trdy_n)
        else $error("blocked access not answered by stop");
    cfg_select_a:
        assert property (acc_valid && acc_kind == ACC_CFG |-> $past(idsel_s))
        else $error("configuration access without select");
    claim_select_a:
        assert property ($fell(devsel_oe_n) |-> $past(claim_w))
        else $error("device select driven without decode");
    suspend_clock_a:
        assert property (susp_w |-> card_clk_en == 2'h0 ##1 !int_clk_en)
        else $error("clock still enabled in suspend");
    low_power_a:
        assert property (lp_w |=> !int_clk_en && card_clk == 2'h0)
        else $error("clocks running in low power");
    perr_drive_a:
        assert property (wchk_q && par_bad_w |=> !perr_n && !perr_oe_n ##1 perr_n && !perr_oe_n)
        else $error("write parity error not reported");
    serr_pulse_a:
        assert property (achk_q && par_bad_w |=> !serr_oe_n ##1 serr_oe_n)
        else $error("address parity error not pulsed");
    idle_release_a:
        assert property (state_q == ST_IDLE |-> trdy_oe_n && stop_oe_n && devsel_oe_n)
        else $error("handshake driven while idle");

    cover property (wr_valid);
    cover property (done_w && !write_q);
    cover property (claim_w && retry_w);
    cover property (serr_q);
    cover property (s2s_valid);
endmodule // pci_card_host_adapter_port

// ===== pci_master_model.sv
// Purpose: initiator model driving single-phase accesses
// Assumes: design samples pins through two flops
// Notes: released ad shows inverse of last value
`timescale 1ns/1ns
module pci_master_model (
    input wire logic core_clk,
    input wire logic trdy_n,
    input wire logic [31:0] ad_in,
    output logic [31:0] ad_out,
    output logic [3:0] cbe_n,
    output logic frame_n,
    output logic irdy_n,
    output logic idsel,
    output logic par,
    output logic [31:0] rdat,
    output logic ack
);
    initial begin
        {frame_n, irdy_n, idsel, par, ack} = 5'h18;
        cbe_n = 4'hF;
        ad_out = 32'h0;
        rdat = 32'h0;
    end
    task automatic xfer(input logic [3:0] cmd, input logic [31:0] a, d,
                        input logic [3:0] be, input logic sel, bad);
        int i;
        @(posedge core_clk);
        frame_n <= 1'b0;
        ad_out <= a;
        cbe_n <= cmd;
        idsel <= sel;
        @(posedge core_clk);
        par <= (^{a, cmd}) ^ bad;
        frame_n <= 1'b1;
        irdy_n <= 1'b0;
        idsel <= 1'b0;
        cbe_n <= ~be;
        ad_out <= cmd[0] ? d : ~a;
        ack = 1'b0;
        for (i = 0; i < 12 && !ack; i++) begin
            @(posedge core_clk);
            par <= ^{d, ~be};
            ack = !trdy_n;
            rdat = ad_in;
        end
        irdy_n <= 1'b1;
        ad_out <= ~d;
    endtask
endmodule // pci_master_model

// ===== tb_pci_card_host_adapter_port.sv
// Purpose: scenario bench of the target port
// Assumes: window and legacy ports idle outside t_win and t_legacy
// Notes: event counters compared as deltas
`timescale 1ns/1ns
`include "pci_card_defs.svh"
module tb_pci_card_host_adapter_port
    import pci_card_pkg::*;
();
    logic core_clk = 0, rst_n = 0, suspend_sw = 0, auto_lp_en = 0;
    logic trdy_n, stop_n, devsel_drv_n, devsel_oe_n, ad_oe_n, serr_oe_n;
    logic trdy_oe_n, stop_oe_n, acc_valid, wr_valid, int_clk_en, frame_n, irdy_n, idsel, par;
    logic [31:0] ad, ad_m, ad_drv, wr_data, rd_data = 32'h3C5A9617;
    logic [3:0] cbe_n, wr_be;
    acc_kind_t acc_kind;
    logic lock_n = 1, suspend_hw = 0, legacy_en = 0, win_we = 0, win_sock = 0, win_en = 0;
    logic win_io = 0, win_xlate = 0, mst_valid = 0, s2s_en = 0, acc_sock, acc_xlate;
    logic s2s_valid, s2s_dst;
    logic [2:0] win_idx = 3'h0;
    logic [1:0] act_en = 2'h0, act_clr = 2'h0, act_flag;
    logic [31:0] win_base = 32'h0, win_limit = 32'h0, mst_addr = 32'h0;
    logic [31:0] legacy_io_base = 32'h10;
    irq_mode_t irq_mode_sel = IRQ_PCI, irq_mode;
    int errors = 0, n_checks = 0, c_acc = 0, c_serr = 0, c_stop = 0, c_dev = 0, a0, s0, p0, d0;
    assign ad = ad_oe_n ? ad_m : ad_drv;
    initial forever #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        c_acc <= c_acc + acc_valid;
        c_serr <= c_serr + !serr_oe_n;
        c_stop <= c_stop + !stop_n;
        c_dev <= c_dev + !devsel_oe_n;
    end
    pci_master_model mst_u (.core_clk(core_clk), .trdy_n(trdy_n), .ad_in(ad), .ad_out(ad_m),
        .cbe_n(cbe_n), .frame_n(frame_n), .irdy_n(irdy_n), .idsel(idsel), .par(par),
        .rdat(), .ack());
    pci_card_host_adapter_port dut_u (.core_clk(core_clk), .rst_n(rst_n), .ad(ad),
        .ad_drv(ad_drv), .ad_oe_n(ad_oe_n), .cbe_n(cbe_n), .frame_n(frame_n), .irdy_n(irdy_n),
        .trdy_n(trdy_n), .trdy_oe_n(trdy_oe_n), .stop_n(stop_n), .stop_oe_n(stop_oe_n),
        .devsel_n(devsel_oe_n | devsel_drv_n), .devsel_drv_n(devsel_drv_n),
        .devsel_oe_n(devsel_oe_n), .lock_n(lock_n), .idsel(idsel), .par(par), .par_drv(),
        .par_oe_n(), .perr_n(), .perr_oe_n(), .serr_n(), .serr_oe_n(serr_oe_n),
        .suspend_hw(suspend_hw), .suspend_sw(suspend_sw), .auto_lp_en(auto_lp_en),
        .int_clk_en(int_clk_en), .sock_en(2'h3), .card_div(8'h44), .card_clk(),
        .card_clk_en(), .legacy_en(legacy_en), .legacy_io_base(legacy_io_base),
        .legacy_mem_base(32'h0), .win_we(win_we), .win_sock(win_sock), .win_idx(win_idx),
        .win_en(win_en), .win_io(win_io), .win_xlate(win_xlate), .win_base(win_base),
        .win_limit(win_limit), .irq_mode_sel(irq_mode_sel), .irq_mode(irq_mode),
        .act_en(act_en), .act_clr(act_clr), .act_flag(act_flag), .mst_valid(mst_valid),
        .mst_src(1'b0), .mst_addr(mst_addr), .s2s_en(s2s_en), .s2s_valid(s2s_valid),
        .s2s_dst(s2s_dst), .s2s_addr(), .acc_valid(acc_valid), .acc_kind(acc_kind),
        .acc_addr(), .acc_write(), .acc_sock(acc_sock), .acc_win(), .acc_xlate(acc_xlate),
        .rd_data(rd_data),
        .wr_valid(wr_valid), .wr_data(wr_data), .wr_be(wr_be), .rd_done(), .other_claim());
    task automatic chk(input logic [31:0] seen, exp, input string m);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    task automatic go(input logic [3:0] cmd, input logic sel, bad);
        {a0, s0, p0, d0} = {c_acc, c_serr, c_stop, c_dev};
        mst_u.xfer(cmd, 32'h10, 32'hA5C30F1E, 4'h5, sel, bad);
        repeat (6) @(posedge core_clk);
    endtask
    task automatic t_cfg_wr();
        go(`CMD_CFG_WR, 1'b1, 1'b0);
        chk(c_acc - a0, 1, "cfg write not claimed");
        chk(c_dev != d0, 1, "devsel not driven");
        chk(acc_kind, ACC_CFG, "kind");
        chk(wr_data, 32'hA5C30F1E, "write data");
        chk(wr_be, 4'h5, "byte enables");
    endtask
    task automatic t_cfg_rd();
        go(`CMD_CFG_RD, 1'b1, 1'b0);
        chk(mst_u.ack, 1'b1, "no target ready");
        chk(mst_u.rdat, rd_data, "read data");
    endtask
    task automatic t_nosel();
        go(`CMD_CFG_WR, 1'b0, 1'b0);
        chk(c_acc - a0 + c_dev - d0, 0, "claimed without select");
    endtask
    task automatic t_serr();
        go(`CMD_CFG_WR, 1'b1, 1'b1);
        chk(c_serr - s0, 1, "no system error pulse");
    endtask
    task automatic t_susp();
        suspend_sw <= 1'b1;
        go(`CMD_CFG_RD, 1'b1, 1'b0);
        chk(int_clk_en, 1'b0, "clock runs in suspend");
        chk({c_stop != p0, mst_u.ack}, 2'h2, "suspend not refused");
        suspend_sw <= 1'b0;
        suspend_hw <= 1'b1;
        repeat (4) @(posedge core_clk);
        chk(int_clk_en, 1'b0, "clock runs in hardware suspend");
        suspend_hw <= 1'b0;
    endtask
    task automatic t_win();
        irq_mode_sel <= IRQ_VENDOR;
        {win_we, win_sock, win_idx, win_en, win_io, win_xlate} <= {2'h3, 3'h2, 3'h7};
        {win_base, win_limit, act_en} <= {32'h10, 32'h1F, 2'h2};
        @(posedge core_clk);
        win_we <= 1'b0;
        go(`CMD_MEM_RD, 1'b0, 1'b0);
        chk(c_acc - a0, 1, "window not claimed");
        chk({acc_sock, acc_xlate, acc_kind}, {2'h3, ACC_MEM}, "memory not translated");
        chk(act_flag, 2'h2, "activity not flagged");
        chk(irq_mode, IRQ_VENDOR, "interrupt mode not taken");
        act_clr <= 2'h2;
        @(posedge core_clk);
        act_clr <= 2'h0;
        @(posedge core_clk);
        chk(act_flag, 2'h0, "activity not cleared");
    endtask
    task automatic t_legacy();
        legacy_en <= 1'b1;
        go(`CMD_MEM_RD, 1'b0, 1'b0);
        chk(acc_kind, ACC_LEGACY, "legacy memory not claimed");
        go(`CMD_IO_RD, 1'b0, 1'b0);
        chk(c_acc - a0, 1, "legacy io not claimed");
        chk(acc_kind, ACC_LEGACY, "legacy io kind");
        legacy_en <= 1'b0;
    endtask
    task automatic t_s2s();
        {mst_valid, s2s_en, mst_addr} <= {2'h3, 32'h14};
        @(posedge core_clk);
        mst_valid <= 1'b0;
        @(posedge core_clk);
        chk({s2s_valid, s2s_dst}, 2'h3, "no socket transfer");
    endtask
    task automatic t_lock();
        lock_n <= 1'b0;
        go(`CMD_MEM_RD, 1'b0, 1'b0);
        go(`CMD_MEM_RD, 1'b0, 1'b0);
        chk(c_acc - a0, 0, "locked resource not refused");
        chk(c_stop != p0, 1, "no stop on lock");
        lock_n <= 1'b1;
    endtask
    task automatic t_lowpow();
        auto_lp_en <= 1'b1;
        repeat (220) @(posedge core_clk);
        // idle beyond the limit must gate the clock
        chk(int_clk_en, 1'b0, "low power not entered");
    endtask
    task automatic end_of_test();
        if (errors == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        // handshakes stay released while idle
        chk({trdy_oe_n, stop_oe_n, devsel_oe_n, ad_oe_n}, 4'hF, "driven at idle");
        t_cfg_wr();
        t_cfg_rd();
        t_nosel();
        t_serr();
        t_susp();
        t_win();
        t_legacy();
        t_s2s();
        t_lock();
        t_lowpow();
        end_of_test();
    end
    initial begin
        #20000;
        errors++;
        end_of_test();
    end
endmodule // tb_pci_card_host_adapter_port
